// >>> hdl/bkl_map.svh
// Contract
// - Strap code 10 boots over the parallel port from 8-bit wide memory.
// - Strap code 11 is internal boot and starts no external transfer.
// - Parallel control defaults: strobe high, enabled, 23 clocks, receive DMA on.
// - Parallel boot adds a hold cycle, reads 8-bit data, keeps buffer hang.
// - Kernel DMA starts at 0x80000 offset 0, modifier 1, count 0x180 words.
// - External side starts at index 0, modifier 1, count 0x600 bytes.
// - Strap 00 selects serial slave boot, strap 01 serial master boot.
// - Serial receive word is fixed at 32 bits, packed low bit first.
// - Two 16-bit or four 8-bit source words make one internal write.
// - Two 48-bit instructions travel as three 32-bit words.
// - Slave defaults: enabled, slave, low bit first, 32 bits, output off.
// - Slave reset values: control 4D22, DMA control 7, index 80000, count 180.
// - Master boot drives clock, pulls flag 0 low, sends read 0x03 address 0.
// - Master boot comes up as master and moves 384 32-bit words.
// - Master defaults: enabled, master role, low bit first.
// - Master defaults: 32 bits, output on, send zeros, receive DMA, idle high.
// - Master reset: rate divider 0x0064, flag register 0xfe01.
// - Master discards the word received during the command word.
`ifndef BKL_MAP_SVH
`define BKL_MAP_SVH

`define BKL_STRAP_SLAVE    2'b00
`define BKL_STRAP_MASTER   2'b01
`define BKL_STRAP_PARALLEL 2'b10

`define BKL_PP_RST     32'h0000016f
`define BKL_PP_EN      0
`define BKL_PP_DUR_LO  1
`define BKL_PP_DUR_HI  5
`define BKL_PP_BHC     6
`define BKL_PP_WIDE    7
`define BKL_PP_DEN     8
`define BKL_PP_TRAN    9
`define BKL_PP_ALEPL   12
`define BKL_PP_BHD     13

`define BKL_SCTL_SLAVE  32'h00004d22
`define BKL_SCTL_MASTER 32'h00005d06
`define BKL_SDMAC_RST   32'h00000007
`define BKL_BAUD_RST    16'h0064
`define BKL_FLAG_RST    16'hfe01
`define BKL_FLAG_SEL0   0
`define BKL_FLAG_VAL0   8

`define BKL_NW_BASE    20'h80000
`define BKL_INT_IDX    20'h00000
`define BKL_INT_MOD    20'h00001
`define BKL_INT_COUNT  16'h0180
`define BKL_EXT_IDX    20'h00000
`define BKL_EXT_MOD    20'h00001
`define BKL_EXT_COUNT  16'h0600
// Opcode 0x03 as seen MSB first by the memory, shifted out LSB first
`define BKL_RD_CMD     32'h000000c0

`define BKL_OFF_PARALLEL_PORT_CONTROL  8'h00
`define BKL_OFF_SCTL   8'h04
`define BKL_OFF_BAUD   8'h08
`define BKL_OFF_FLAG   8'h0c
`define BKL_OFF_SDMAC  8'h10
`define BKL_OFF_DIDX   8'h14
`define BKL_OFF_DCNT   8'h18
`define BKL_OFF_EIDX   8'h1c
`define BKL_OFF_ECNT   8'h20
`define BKL_OFF_STAT   8'h24

`endif

// >>> hdl/bkl_pkg.sv
`default_nettype none
`include "bkl_map.svh"
package bkl_pkg;
  typedef enum logic [1:0] {BKL_MODE_SLAVE, BKL_MODE_MASTER, BKL_MODE_PARALLEL,
                            BKL_MODE_INTERNAL} bkl_mode_t;
  typedef enum logic [1:0] {BKL_MST_IDLE, BKL_MST_RUN, BKL_MST_DONE} bkl_mst_t;
  typedef enum logic [1:0] {BKL_PF_IDLE, BKL_PF_LATCH, BKL_PF_READ, BKL_PF_HOLD} bkl_pf_t;

  function automatic bkl_mode_t bkl_decode(input logic [1:0] strap);
    unique case (strap)
      `BKL_STRAP_SLAVE:    return BKL_MODE_SLAVE;
      `BKL_STRAP_MASTER:   return BKL_MODE_MASTER;
      `BKL_STRAP_PARALLEL: return BKL_MODE_PARALLEL;
      default:             return BKL_MODE_INTERNAL;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> hdl/bkl_shift32.sv
`default_nettype none
module bkl_shift32
  import bkl_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Serial bits
  input  wire logic        bit_stb,
  input  wire logic        bit_in,
  // Assembled word
  output logic             word_stb,
  output logic [31:0]      word
);
  logic [31:0] sr_q;
  logic [4:0]  cnt_q;

  // Width of the source never matters: narrow words arrive back to back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_q     <= '0;
      cnt_q    <= '0;
      word_stb <= 1'b0;
      word     <= '0;
    end else begin
      word_stb <= 1'b0;
      if (bit_stb) begin
        sr_q  <= {bit_in, sr_q[31:1]};
        cnt_q <= cnt_q + 5'd1;
        if (cnt_q == 5'd31) begin
          word_stb <= 1'b1;
          word     <= {bit_in, sr_q[31:1]};
        end
      end
    end
  end

  full_word_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_stb && cnt_q == 5'd31) |=> (word_stb && word[31] == $past(bit_in)))
    else $error("word not delivered after 32 bits");

  first_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_stb && cnt_q == 5'd31) |=> word[30:0] == $past(sr_q[31:1]))
    else $error("earlier bits not in lower positions");
endmodule
`default_nettype wire

// >>> hdl/bkl_par_fetch.sv
`default_nettype none
module bkl_par_fetch
  import bkl_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request
  input  wire logic        req,
  input  wire logic [19:0] addr,
  input  wire logic [4:0]  duration,
  input  wire logic        hold_en,
  input  wire logic        ale_low,
  output logic             busy,
  output logic             byte_stb,
  output logic [7:0]       byte_q,
  // Pins
  output logic             par_ale,
  output logic [19:0]      par_addr,
  output logic             par_rd_n,
  input  wire logic [7:0]  par_data_i
);
  bkl_pf_t    st_q;
  logic [4:0] cnt_q;

  assign busy = (st_q != BKL_PF_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= BKL_PF_IDLE;
      cnt_q    <= '0;
      byte_stb <= 1'b0;
      byte_q   <= '0;
      par_ale  <= 1'b0;
      par_addr <= '0;
      par_rd_n <= 1'b1;
    end else begin
      byte_stb <= 1'b0;
      unique case (st_q)
        BKL_PF_IDLE: begin
          par_ale <= ale_low;
          if (req) begin
            par_addr <= addr;
            par_ale  <= ~ale_low;
            st_q     <= BKL_PF_LATCH;
          end
        end
        BKL_PF_LATCH: begin
          par_ale  <= ale_low;
          par_rd_n <= 1'b0;
          // A zero duration would wrap to 32 cycles; run it as one cycle
          cnt_q    <= (duration == 5'd0) ? 5'd0 : duration - 5'd1;
          st_q     <= BKL_PF_READ;
        end
        BKL_PF_READ: begin
          if (cnt_q == 5'd0) begin
            par_rd_n <= 1'b1;
            byte_q   <= par_data_i;
            byte_stb <= 1'b1;
            st_q     <= hold_en ? BKL_PF_HOLD : BKL_PF_IDLE;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        BKL_PF_HOLD: st_q <= BKL_PF_IDLE;
      endcase
    end
  end

  hold_cycle_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_q == BKL_PF_READ && cnt_q == 5'd0 && hold_en) |=> st_q == BKL_PF_HOLD ##1 !busy)
    else $error("bus hold cycle missing");
endmodule
`default_nettype wire

// >>> hdl/bkl_loader.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module bkl_loader
  import bkl_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Boot straps
  input  wire logic [1:0]  boot_strap_code,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  // Serial pins
  input  wire logic        serial_clock_line_i,
  output logic             serial_clock_line_o,
  output logic             serial_clock_line_oe,
  input  wire logic        slave_select_in_n,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  output logic             flag_out_zero_n,
  // Parallel pins
  output logic             par_ale,
  output logic [19:0]      par_addr,
  output logic             par_rd_n,
  input  wire logic [7:0]  par_data_i,
  // Internal memory write
  output logic             mem_we,
  output logic [19:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  // Completion
  output logic             spi_boot_done,
  output logic             par_boot_done
);
  function automatic logic [31:0] bkl_strb(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic bkl_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `BKL_OFF_STAT);
  endfunction

  bkl_mode_t   mode_q;
  logic [1:0]  strap_q;
  logic [31:0] parallel_port_control_q;
  logic [15:0] baud_q;
  logic [15:0] flag_q;

  // Straps are caught while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= boot_strap_code;
      mode_q  <= bkl_decode(boot_strap_code);
    end
  end

  // AXI4-Lite write channel
  logic       have_aw_q;
  logic       have_w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       wr_do;

  assign wr_do = have_aw_q && have_w_q && !s_axil_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q      <= 1'b0;
      have_w_q       <= 1'b0;
      awaddr_q       <= '0;
      wdata_q        <= '0;
      wstrb_q        <= '0;
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= 2'b00;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        awaddr_q       <= s_axil_awaddr;
        have_aw_q      <= 1'b1;
        s_axil_awready <= 1'b0;
      end else if (!have_aw_q && !s_axil_bvalid) begin
        s_axil_awready <= 1'b1;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        wdata_q       <= s_axil_wdata;
        wstrb_q       <= s_axil_wstrb;
        have_w_q      <= 1'b1;
        s_axil_wready <= 1'b0;
      end else if (!have_w_q && !s_axil_bvalid) begin
        s_axil_wready <= 1'b1;
      end
      if (wr_do) begin
        have_aw_q     <= 1'b0;
        have_w_q      <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= bkl_mapped(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // Writable controls; the rest of the map is read-only state
  logic [31:0] baud_wr;
  logic [31:0] flag_wr;

  assign baud_wr = bkl_strb({16'h0, baud_q}, wdata_q, wstrb_q);
  assign flag_wr = bkl_strb({16'h0, flag_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parallel_port_control_q <= `BKL_PP_RST;
      baud_q  <= `BKL_BAUD_RST;
      flag_q  <= `BKL_FLAG_RST;
    end else if (wr_do) begin
      case (awaddr_q)
        `BKL_OFF_PARALLEL_PORT_CONTROL: parallel_port_control_q <= bkl_strb(parallel_port_control_q, wdata_q, wstrb_q);
        `BKL_OFF_BAUD:  baud_q  <= (baud_wr == 32'h0) ? baud_q : baud_wr[15:0];
        `BKL_OFF_FLAG:  flag_q  <= flag_wr[15:0];
        default: ;
      endcase
    end
  end

  // Kernel DMA into internal memory
  logic [19:0] int_index_q;
  logic [15:0] int_count_q;
  logic        skip_q;
  logic        sr_word_stb;
  logic [31:0] sr_word;
  logic        par_word_stb_q;
  logic [31:0] par_word_q;
  logic        spi_mode;
  logic        spi_word_ok;
  logic        mem_wr_go;

  assign spi_mode    = (mode_q == BKL_MODE_SLAVE) || (mode_q == BKL_MODE_MASTER);
  assign spi_word_ok = sr_word_stb && spi_mode && !(skip_q && mode_q == BKL_MODE_MASTER);
  assign mem_wr_go   = (spi_word_ok || par_word_stb_q) && (int_count_q != 16'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_index_q   <= `BKL_INT_IDX;
      int_count_q   <= `BKL_INT_COUNT;
      skip_q        <= 1'b1;
      mem_we        <= 1'b0;
      mem_addr      <= '0;
      mem_wdata     <= '0;
      spi_boot_done <= 1'b0;
      par_boot_done <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      // The word shifted in under the read command is garbage
      if (sr_word_stb && mode_q == BKL_MODE_MASTER) skip_q <= 1'b0;
      if (mem_wr_go) begin
        // Words land in arrival order, so three words rebuild two instructions
        mem_we      <= 1'b1;
        mem_addr    <= `BKL_NW_BASE + int_index_q;
        mem_wdata   <= spi_word_ok ? sr_word : par_word_q;
        int_index_q <= int_index_q + `BKL_INT_MOD;
        int_count_q <= int_count_q - 16'h1;
        if (int_count_q == 16'h1) begin
          if (mode_q == BKL_MODE_PARALLEL) par_boot_done <= 1'b1;
          else spi_boot_done <= 1'b1;
        end
      end
    end
  end

  // Parallel port byte stream
  logic        par_go;
  logic        pf_req_q;
  logic [19:0] pf_addr_q;
  logic [19:0] ext_index_q;
  logic [15:0] ext_count_q;
  logic [31:0] pw_q;
  logic [1:0]  pb_q;
  logic        pf_busy;
  logic        pf_byte_stb;
  logic [7:0]  pf_byte;

  // Only the 8-bit receive setup is a valid boot path
  assign par_go = (mode_q == BKL_MODE_PARALLEL) && parallel_port_control_q[`BKL_PP_EN] &&
                  parallel_port_control_q[`BKL_PP_DEN] && !parallel_port_control_q[`BKL_PP_TRAN] &&
                  !parallel_port_control_q[`BKL_PP_WIDE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pf_req_q       <= 1'b0;
      pf_addr_q      <= '0;
      ext_index_q    <= `BKL_EXT_IDX;
      ext_count_q    <= `BKL_EXT_COUNT;
      pw_q           <= '0;
      pb_q           <= '0;
      par_word_stb_q <= 1'b0;
      par_word_q     <= '0;
    end else begin
      pf_req_q       <= 1'b0;
      par_word_stb_q <= 1'b0;
      if (par_go && !pf_busy && !pf_req_q && ext_count_q != 16'h0) begin
        pf_req_q    <= 1'b1;
        pf_addr_q   <= ext_index_q;
        ext_index_q <= ext_index_q + `BKL_EXT_MOD;
        ext_count_q <= ext_count_q - 16'h1;
      end
      if (pf_byte_stb) begin
        pw_q <= {pf_byte, pw_q[31:8]};
        pb_q <= pb_q + 2'd1;
        if (pb_q == 2'd3) begin
          par_word_stb_q <= 1'b1;
          par_word_q     <= {pf_byte, pw_q[31:8]};
        end
      end
    end
  end

  bkl_par_fetch u_fetch (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .req        (pf_req_q),
    .addr       (pf_addr_q),
    .duration   (parallel_port_control_q[`BKL_PP_DUR_HI:`BKL_PP_DUR_LO]),
    .hold_en    (parallel_port_control_q[`BKL_PP_BHC]),
    .ale_low    (parallel_port_control_q[`BKL_PP_ALEPL]),
    .busy       (pf_busy),
    .byte_stb   (pf_byte_stb),
    .byte_q     (pf_byte),
    .par_ale    (par_ale),
    .par_addr   (par_addr),
    .par_rd_n   (par_rd_n),
    .par_data_i (par_data_i)
  );

  // Serial master: clock idles high, data moves on falling, sampled on rising
  bkl_mst_t    mst_q;
  logic [16:0] div_q;
  logic [31:0] tx_q;
  logic        mst_bit;
  logic        sclk_prev_q;
  logic        ss_prev_q;
  logic        armed_q;
  logic        slv_bit;

  assign mst_bit = (mst_q == BKL_MST_RUN) && (div_q == 17'h0) && !serial_clock_line_o;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_q                <= BKL_MST_IDLE;
      div_q                <= '0;
      tx_q                 <= `BKL_RD_CMD;
      serial_clock_line_o  <= 1'b1;
      serial_clock_line_oe <= 1'b0;
      mosi_o               <= 1'b0;
      mosi_oe              <= 1'b0;
      flag_out_zero_n      <= 1'b1;
    end else begin
      unique case (mst_q)
        BKL_MST_IDLE: begin
          if (mode_q == BKL_MODE_MASTER) begin
            mst_q                <= BKL_MST_RUN;
            serial_clock_line_oe <= 1'b1;
            mosi_oe              <= 1'b1;
            flag_out_zero_n      <= flag_q[`BKL_FLAG_VAL0] | ~flag_q[`BKL_FLAG_SEL0];
            div_q                <= {baud_q, 1'b0};
          end
        end
        BKL_MST_RUN: begin
          if (spi_boot_done) begin
            mst_q                <= BKL_MST_DONE;
            serial_clock_line_o  <= 1'b1;
            serial_clock_line_oe <= 1'b0;
            mosi_oe              <= 1'b0;
            flag_out_zero_n      <= 1'b1;
          end else if (div_q == 17'h0) begin
            // Half period is twice the divider plus one cycle, so the bit rate is the core clock over 4x+2
            div_q               <= {baud_q, 1'b0};
            serial_clock_line_o <= ~serial_clock_line_o;
            if (serial_clock_line_o) begin
              mosi_o <= tx_q[0];
              tx_q   <= {1'b0, tx_q[31:1]};
            end
          end else begin
            div_q <= div_q - 17'h1;
          end
        end
        BKL_MST_DONE: ;
      endcase
    end
  end

  // Serial slave: host owns the clock; select must fall before bits count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_q <= 1'b1;
      ss_prev_q   <= 1'b1;
      armed_q     <= 1'b0;
      miso_o      <= 1'b0;
      miso_oe     <= 1'b0;
    end else begin
      sclk_prev_q <= serial_clock_line_i;
      ss_prev_q   <= slave_select_in_n;
      if (ss_prev_q && !slave_select_in_n) armed_q <= 1'b1;
      else if (slave_select_in_n) armed_q <= 1'b0;
    end
  end

  assign slv_bit = (mode_q == BKL_MODE_SLAVE) && armed_q && !slave_select_in_n &&
                   !sclk_prev_q && serial_clock_line_i && !spi_boot_done;

  bkl_shift32 u_shift (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .bit_stb  (mst_bit || slv_bit),
    .bit_in   ((mode_q == BKL_MODE_MASTER) ? miso_i : mosi_i),
    .word_stb (sr_word_stb),
    .word     (sr_word)
  );

  // AXI4-Lite read channel
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (s_axil_araddr)
      `BKL_OFF_PARALLEL_PORT_CONTROL: rd_mux = parallel_port_control_q;
      `BKL_OFF_SCTL:  rd_mux = (mode_q == BKL_MODE_SLAVE)  ? `BKL_SCTL_SLAVE :
                               (mode_q == BKL_MODE_MASTER) ? `BKL_SCTL_MASTER : 32'h0;
      `BKL_OFF_BAUD:  rd_mux = {16'h0, baud_q};
      `BKL_OFF_FLAG:  rd_mux = {16'h0, flag_q};
      `BKL_OFF_SDMAC: rd_mux = spi_mode ? `BKL_SDMAC_RST : 32'h0;
      `BKL_OFF_DIDX:  rd_mux = {12'h0, `BKL_NW_BASE + int_index_q};
      `BKL_OFF_DCNT:  rd_mux = {16'h0, int_count_q};
      `BKL_OFF_EIDX:  rd_mux = {12'h0, ext_index_q};
      `BKL_OFF_ECNT:  rd_mux = {16'h0, ext_count_q};
      `BKL_OFF_STAT:  rd_mux = {28'h0, par_boot_done, spi_boot_done, strap_q};
      default:        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= '0;
      s_axil_rresp   <= 2'b00;
    end else begin
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_arready <= 1'b0;
        s_axil_rvalid  <= 1'b1;
        s_axil_rdata   <= rd_mux;
        s_axil_rresp   <= bkl_mapped(s_axil_araddr) ? 2'b00 : 2'b10;
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end else if (!s_axil_rvalid) begin
        s_axil_arready <= 1'b1;
      end
    end
  end

  // Checks
  sequence last_write_s;
    mem_wr_go && int_count_q == 16'h0001;
  endsequence

  sequence master_first_word_s;
    mode_q == BKL_MODE_MASTER && sr_word_stb && skip_q;
  endsequence

  par_strap_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mode_q == BKL_MODE_PARALLEL) == (strap_q == `BKL_STRAP_PARALLEL))
    else $error("parallel mode does not follow strap");

  internal_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    mode_q == BKL_MODE_INTERNAL |-> !mem_we && serial_clock_line_oe == 1'b0)
    else $error("internal boot started an external transfer");

  pp_default_a: assert property (
    @(posedge aclk) $rose(aresetn) |-> parallel_port_control_q == `BKL_PP_RST)
    else $error("parallel control reset value wrong");

  int_sum_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    int_count_q + int_index_q[15:0] == `BKL_INT_COUNT)
    else $error("internal index and count out of step");

  ext_sum_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ext_count_q + ext_index_q[15:0] == `BKL_EXT_COUNT)
    else $error("external index and count out of step");

  discard_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    master_first_word_s |=> !mem_we)
    else $error("command-time word was stored");

  done_after_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    last_write_s |=> (spi_boot_done || par_boot_done) && mem_we)
    else $error("completion not raised after last word");

  select_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mst_q == BKL_MST_RUN && flag_q == `BKL_FLAG_RST) |-> !flag_out_zero_n)
    else $error("flag 0 not low during master boot");
endmodule
`default_nettype wire

// >>> hdl/bkl_loader_fix.sv
`default_nettype none
`default_nettype wire

// >>> verif/bkl_pmem.sv
`default_nettype none
module bkl_pmem (
  // Clock
  input  wire logic        aclk,
  // Bus from loader
  input  wire logic [19:0] par_addr,
  input  wire logic        par_rd_n,
  // Byte to loader
  output logic [7:0]       par_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q;
  always_ff @(posedge aclk) last_q <= par_data;
  // Idle bus toggles so stale bytes never pass as data
  always_comb par_data = par_rd_n ? ~last_q : par_addr[7:0] ^ 8'h5a;
endmodule
`default_nettype wire

// >>> verif/tb_boot_kernel_loader.sv
`default_nettype none
module tb_boot_kernel_loader;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, we, awr, wrd, bv;
  logic        sck = 1, ssn = 1, mosi = 0, arr, rv, sd, pd, prd, so, soe, mo, moe, fz, mi = 0;
  logic [1:0]  strap = 0, br, rr;
  logic [7:0]  awa = 0, ara = 0, pdat;
  logic [19:0] pa, ma;
  logic [31:0] wd = 0, rdat, mw, w, c;
  int          fails = 0, checked = 0, n;
  // Parallel rows: one byte fetch is already issued when the read lands
  logic [43:0] rows [11] = '{44'h004_00004d22, 44'h010_00000007, 44'h014_00080000,
    44'h018_00000180, 44'h104_00005d06, 44'h108_00000064, 44'h10c_0000fe01,
    44'h200_0000016f, 44'h21c_00000001, 44'h220_000005ff, 44'h324_00000003};
  bkl_loader dut (.aclk(clk), .aresetn(rn), .boot_strap_code(strap),
    .s_axil_awaddr(awa), .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_wdata(wd),
    .s_axil_wstrb(4'hf), .s_axil_wvalid(wv), .s_axil_wready(wrd), .s_axil_bresp(br),
    .s_axil_bvalid(bv), .s_axil_bready(bre), .s_axil_araddr(ara), .s_axil_arvalid(arv),
    .s_axil_arready(arr), .s_axil_rdata(rdat), .s_axil_rresp(rr), .s_axil_rvalid(rv),
    .s_axil_rready(rre), .serial_clock_line_i(sck), .serial_clock_line_o(so),
    .serial_clock_line_oe(soe), .slave_select_in_n(ssn), .mosi_i(mosi), .mosi_o(mo),
    .mosi_oe(moe), .miso_i(mi), .miso_o(), .miso_oe(), .flag_out_zero_n(fz), .par_ale(),
    .par_addr(pa), .par_rd_n(prd), .par_data_i(pdat), .mem_we(we), .mem_addr(ma),
    .mem_wdata(mw), .spi_boot_done(sd), .par_boot_done(pd));
  bkl_pmem mem (.aclk(clk), .par_addr(pa), .par_rd_n(prd), .par_data(pdat));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [33:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rst(input logic [1:0] s);
    rn <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk);
    rn <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] p);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    rre <= 1'b0;
    chk({rr, rdat}, {p, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] p);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while ((awv && awr !== 1'b1) || (wv && wrd !== 1'b1));
    while (bv !== 1'b1) @(posedge clk);
    bre <= 1'b0;
    chk(34'(br), 34'(p));
  endtask
  task automatic wwe(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (we !== 1'b1 && n < lim);
    chk(34'(we), 34'h1);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      rst(rows[i][41:40]);
      rd(rows[i][39:32], rows[i][31:0], 2'b00);
    end
    rst(2'b01);
    wr(8'h08, 32'h5, 2'b00);
    rd(8'h08, 32'h5, 2'b00);
    wr(8'h04, 32'h0, 2'b00);
    rd(8'h04, 32'h5d06, 2'b00);
    wr(8'h44, 32'h0, 2'b10);
    rd(8'h44, 32'h0, 2'b10);
    chk(34'({fz, soe, moe}), 34'h3);
    // First frame carries the command and returns junk ones; the second is stored
    w = 32'h8e3c71a5;
    for (int i = 0; i < 64; i++) begin
      do @(posedge clk); while (so !== 1'b0);
      mi <= (i < 32) || w[i[4:0]];
      if (i < 32) c[i] = mo;
      do @(posedge clk); while (so !== 1'b1);
    end
    // Opcode 0x03 leaves high bit first, so the low-first word reads 0xc0
    chk(c, 32'h000000c0);
    wwe(20);
    chk(mw, w);
    chk(34'(ma), 34'h80000);
    // Select starts high so the loader sees a real falling edge
    rst(2'b00);
    ssn <= 1'b0;
    w = 32'h33445566;
    for (int i = 0; i < 32; i++) begin
      repeat (2) @(posedge clk);
      sck <= 1'b0;
      mosi <= w[i];
      repeat (2) @(posedge clk);
      sck <= 1'b1;
    end
    wwe(20);
    chk(mw, w);
    chk(34'(ma), 34'h80000);
    rst(2'b10);
    for (int k = 0; k < 384; k++) begin
      wwe(300);
      for (int b = 0; b < 4; b++) w[8*b +: 8] = 8'(4*k+b) ^ 8'h5a;
      chk(mw, w);
      chk(34'(ma), 34'h80000 + 34'(k));
    end
    repeat (3) @(posedge clk);
    chk(34'(pd), 34'h1);
    tally_and_finish();
  end
  initial begin
    #6000000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
